// *** shared/tcsp_pkg.sv ***
// Purpose: Constants and types for the tracker configuration serial port
// Assumes: 10 MHz system clock, two-wire link sampled by that clock
// Notes:   All timing counts derive from printed times and the clock rate
package tcsp_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam logic [6:0] DEV_ADDR = 7'h50;  // Arbitrary neutral slave address

  localparam logic [7:0] REG_OC_THRESH = 8'h0D;
  localparam logic [7:0] REG_OC_CTRL   = 8'h0E;
  localparam logic [7:0] REG_RST_CTRL  = 8'h11;
  localparam logic [7:0] NV_OFFSET     = 8'h20;
  localparam logic [7:0] CMD_REBOOT    = 8'hC4;
  localparam logic [7:0] RESET_VAL     = 8'h00;

  localparam int OC_FILT_MSB  = 7;
  localparam int OC_FILT_LSB  = 6;
  localparam int OC_EN_CH1    = 5;
  localparam int RST_SEL_CH1  = 7;
  localparam int RST_TMO_MSB  = 3;
  localparam int RST_TMO_LSB  = 1;

  // Times in microseconds
  localparam int unsigned OC_FILT_US [4] = '{12500, 50000, 100000, 200000};
  localparam int unsigned RST_TMO_US [8] =
    '{25, 12500, 25000, 50000, 100000, 200000, 400000, 1600000};
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;

  typedef struct packed {
    logic [7:0] oc_thresh;
    logic [7:0] oc_ctrl;
    logic [7:0] rst_ctrl;
  } tcsp_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_WDAT = 3'b011,
    ST_RDAT = 3'b100,
    ST_ACK  = 3'b101,
    ST_RACK = 3'b110,
    ST_SKIP = 3'b111
  } tcsp_state_t;
endpackage

// *** logic/tcsp_top.sv ***
// Purpose: Two-wire slave reaching overcurrent and reset configuration
// Assumes: Link at most 400 kHz, sampled by the 10 MHz clock
// Notes:   Stored copies sit at register offset plus 20h; no real cell wear
`timescale 1ns/1ps
// Function
// [R1] Threshold register holds four 2-bit codes, channel 4 top, channel 1 low.
// [R2] Control bits 7:6 pick filter time 12.5, 50, 100 or 200 ms.
// [R3] Control bits 5..2 enable overcurrent monitoring on channels 1..4.
// [R4] All configuration and stored copies start as zero.
// [R5] Master writes volatile, reads back, then writes stored copies.
// [R6] Stored copies survive power loss; they ignore the logic reset.
// [R7] Command C4h copies stored configuration into volatile registers.
// [R8] Reset control bits 7..4 include channels 1..4 in the reset output.
// [R9] Reset bits 3:1 select timeout 25 us up to 1600 ms.
// [R10] Timeout code 110 is taken as 400 ms.
// [R11] Slave only; never drives clock; link up to 400 kHz.
// [R12] Master frames each transaction with start and stop.
// [R13] Each byte is eight bits followed by receiver acknowledge.
// [R14] Data changes only while clock low; changes while high mark conditions.
// [R15] Start is data falling with clock high; stop is data rising.
// [R16] Repeated start keeps the transaction alive.
// [R17] Stop aborts any transfer except in the start's high pulse.
// [R18] Alarm asserts low after overcurrent outlasts filter time on enabled channel.
// [R19] Monitoring runs only after power-up completes, never during power-down.
// [R20] Reset stays low until selected channels good for the timeout.
module tcsp_top
(
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  // Two-wire link
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output logic                     o_sda,
  output logic                     o_sda_oe,
  // Supervisor status
  input  wire logic [3:0]          i_overcurrent,
  input  wire logic [3:0]          i_power_good_output,
  input  wire logic                i_powerup_done,
  input  wire logic                i_powerdown,
  // Outputs to supervisor
  output logic                     o_overcurrent_alarm_n,
  output logic                     o_reset_n,
  output tcsp_pkg::tcsp_cfg_t      o_cfg
);
  // Synchronisers
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_q, sda_q;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], i_scl};
      sda_s_q <= {sda_s_q[0], i_sda};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end

  wire scl_now  = scl_s_q[1];
  wire sda_now  = sda_s_q[1];
  wire scl_rise = scl_now & ~scl_q;
  wire scl_fall = ~scl_now & scl_q;
  wire start_c  = scl_now & scl_q & sda_q & ~sda_now;  // [R15] [R14] [R16]
  wire stop_c   = scl_now & scl_q & ~sda_q & sda_now;  // [R15] [R14]

  tcsp_pkg::tcsp_state_t st_q, ret_q;
  logic [7:0] sh_q, ptr_q;
  logic [2:0] bit_q;
  logic       rw_q, drive_q, cmd_q, in_start_q, reboot_q;
  logic [7:0] vol_q [3];
  // Factory state of the stored copies; no logic reset reaches them [R4]
  logic [7:0] nv_q  [3] = '{default: tcsp_pkg::RESET_VAL};

  // Map pointer to slot
  wire [1:0] vsel = (ptr_q == tcsp_pkg::REG_OC_THRESH) ? 2'd0 :
                    (ptr_q == tcsp_pkg::REG_OC_CTRL)   ? 2'd1 :
                    (ptr_q == tcsp_pkg::REG_RST_CTRL)  ? 2'd2 : 2'd3;
  wire [7:0] nptr = ptr_q - tcsp_pkg::NV_OFFSET;
  wire [1:0] nsel = (nptr == tcsp_pkg::REG_OC_THRESH) ? 2'd0 :
                    (nptr == tcsp_pkg::REG_OC_CTRL)   ? 2'd1 :
                    (nptr == tcsp_pkg::REG_RST_CTRL)  ? 2'd2 : 2'd3;
  wire [7:0] rd_byte = (vsel != 2'd3) ? vol_q[vsel] :
                       (nsel != 2'd3) ? nv_q[nsel] : 8'h00;
  wire [7:0] sh_next = {sh_q[6:0], sda_now};
  wire       rd_bit  = (bit_q == 3'h0) ? rd_byte[7] : sh_q[3'h7 - bit_q];
  wire       addr_hit = (sh_next[7:1] == tcsp_pkg::DEV_ADDR);

  // Byte engine; acknowledge driven low through the enable only
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      st_q       <= tcsp_pkg::ST_IDLE;
      ret_q      <= tcsp_pkg::ST_IDLE;
      sh_q       <= 8'h00;
      ptr_q      <= 8'h00;
      bit_q      <= 3'h0;
      rw_q       <= 1'b0;
      drive_q    <= 1'b0;
      cmd_q      <= 1'b0;
      in_start_q <= 1'b0;
      reboot_q   <= 1'b0;
    end
    else
    begin
      reboot_q <= 1'b0;
      if (scl_fall)
        in_start_q <= 1'b0;
      if (start_c)
      begin
        st_q       <= tcsp_pkg::ST_ADDR;  // [R16]
        bit_q      <= 3'h0;
        drive_q    <= 1'b0;
        in_start_q <= 1'b1;
      end
      else if (stop_c && !in_start_q)
      begin
        st_q    <= tcsp_pkg::ST_IDLE;  // [R17]
        drive_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st_q)
          tcsp_pkg::ST_ADDR, tcsp_pkg::ST_CMD, tcsp_pkg::ST_WDAT:
          begin
            sh_q  <= sh_next;
            bit_q <= bit_q + 3'h1;  // [R13]
            if (bit_q == 3'h7)
            begin
              if (st_q == tcsp_pkg::ST_ADDR)
              begin
                rw_q  <= sh_next[0];
                ret_q <= addr_hit ? (sh_next[0] ? tcsp_pkg::ST_RDAT : tcsp_pkg::ST_CMD)
                                  : tcsp_pkg::ST_SKIP;
              end
              else if (st_q == tcsp_pkg::ST_CMD)
              begin
                ptr_q    <= sh_next;
                reboot_q <= (sh_next == tcsp_pkg::CMD_REBOOT);  // [R7]
                ret_q    <= tcsp_pkg::ST_WDAT;
              end
              else
                ret_q <= tcsp_pkg::ST_WDAT;
              cmd_q <= (st_q == tcsp_pkg::ST_WDAT);
              st_q  <= (st_q == tcsp_pkg::ST_ADDR && !addr_hit) ? tcsp_pkg::ST_SKIP
                                                                : tcsp_pkg::ST_ACK;
            end
          end
          tcsp_pkg::ST_ACK:
          begin
            st_q  <= ret_q;
            bit_q <= 3'h0;
            if (cmd_q)
              ptr_q <= ptr_q + 8'h01;
            cmd_q <= 1'b0;
          end
          tcsp_pkg::ST_RDAT:
          begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7)
              st_q <= tcsp_pkg::ST_RACK;  // [R13]
          end
          tcsp_pkg::ST_RACK:
          begin
            st_q  <= sda_now ? tcsp_pkg::ST_SKIP : tcsp_pkg::ST_RDAT;  // [R13]
            bit_q <= 3'h0;
            ptr_q <= ptr_q + 8'h01;
          end
          default:
            st_q <= st_q;
        endcase
      end
      else if (scl_fall)
      begin
        // Drive only while clock low, so no false condition is made [R14] [R11]
        case (st_q)
          tcsp_pkg::ST_ACK:
            drive_q <= 1'b1;
          tcsp_pkg::ST_RDAT:
          begin
            // Bit count 0 here only on the fall closing an acknowledge: fetch
            if (bit_q == 3'h0)
              sh_q <= rd_byte;
            drive_q <= ~rd_bit;  // [R13]
          end
          default:
            drive_q <= 1'b0;
        endcase
      end
    end

  // Write strobes for volatile and stored copies
  wire wr_stb = scl_rise && (st_q == tcsp_pkg::ST_WDAT) && (bit_q == 3'h7);

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_reg
      always_ff @(posedge i_clk or negedge i_rstn)
        if (!i_rstn)
          vol_q[g] <= tcsp_pkg::RESET_VAL;  // [R4]
        else if (reboot_q)
          vol_q[g] <= nv_q[g];  // [R7]
        else if (wr_stb && vsel == 2'(g))
          vol_q[g] <= sh_next;  // [R1] [R2] [R3] [R8] [R9]
      // No reset: contents persist like nonvolatile cells [R6] [R5]
      always_ff @(posedge i_clk)
        if (wr_stb && nsel == 2'(g))
          nv_q[g] <= sh_next;
    end
  endgenerate

  // Overcurrent filter
  wire [1:0] filt_code = vol_q[1][tcsp_pkg::OC_FILT_MSB:tcsp_pkg::OC_FILT_LSB];  // [R2]
  wire [31:0] filt_cyc = tcsp_pkg::OC_FILT_US[filt_code] * tcsp_pkg::CYC_PER_US;
  logic [3:0] oc_s1_q, oc_s2_q, pg_s1_q, pg_s2_q;
  logic       pud_s1_q, pud_s2_q, pdn_s1_q, pdn_s2_q;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      {oc_s1_q, oc_s2_q, pg_s1_q, pg_s2_q} <= 16'h0000;
      {pud_s1_q, pud_s2_q, pdn_s1_q, pdn_s2_q} <= 4'h0;
    end
    else
    begin
      oc_s1_q  <= i_overcurrent;
      oc_s2_q  <= oc_s1_q;
      pg_s1_q  <= i_power_good_output;
      pg_s2_q  <= pg_s1_q;
      pud_s1_q <= i_powerup_done;
      pud_s2_q <= pud_s1_q;
      pdn_s1_q <= i_powerdown;
      pdn_s2_q <= pdn_s1_q;
    end

  wire [3:0] oc_en = {vol_q[1][2], vol_q[1][3], vol_q[1][4], vol_q[1][tcsp_pkg::OC_EN_CH1]};  // [R3]
  wire       mon_on = pud_s2_q & ~pdn_s2_q;  // [R19]
  wire       oc_any = mon_on & |(oc_s2_q & oc_en);
  logic [31:0] oc_cnt_q;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      oc_cnt_q              <= 32'h0;
      o_overcurrent_alarm_n <= 1'b1;
    end
    else
    begin
      oc_cnt_q <= oc_any ? ((oc_cnt_q > filt_cyc) ? oc_cnt_q : oc_cnt_q + 32'h1) : 32'h0;
      o_overcurrent_alarm_n <= ~(oc_any && oc_cnt_q >= filt_cyc);  // [R18]
    end

  // Reset timeout
  wire [3:0] rst_sel = {vol_q[2][4], vol_q[2][5], vol_q[2][6], vol_q[2][tcsp_pkg::RST_SEL_CH1]};  // [R8]
  wire [2:0] tmo_code = vol_q[2][tcsp_pkg::RST_TMO_MSB:tcsp_pkg::RST_TMO_LSB];  // [R9] [R10]
  wire [31:0] tmo_cyc = tcsp_pkg::RST_TMO_US[tmo_code] * tcsp_pkg::CYC_PER_US;
  wire        all_good = &(pg_s2_q | ~rst_sel);
  logic [31:0] rst_cnt_q;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      rst_cnt_q <= 32'h0;
      o_reset_n <= 1'b0;
    end
    else
    begin
      rst_cnt_q <= all_good ? ((rst_cnt_q >= tmo_cyc) ? rst_cnt_q : rst_cnt_q + 32'h1) : 32'h0;
      o_reset_n <= all_good && rst_cnt_q >= tmo_cyc;  // [R20]
    end

  assign o_sda    = 1'b0;
  assign o_sda_oe = drive_q;
  assign o_cfg    = '{oc_thresh: vol_q[0], oc_ctrl: vol_q[1], rst_ctrl: vol_q[2]};
endmodule

// *** bench/tcsp_master.sv ***
// Purpose: Two-wire bus master model
// Assumes: Tasks start just after an i_clk edge
// Notes:   Pulled-up lines; a released line reads high
`timescale 1ns/1ps
module tcsp_master
(
  // Link
  output logic      o_scl = 1'b1,
  output logic      o_sda_low = 1'b0,
  input  wire logic i_sda
);
  localparam int QTR = 200;
  // Master alone clocks the link
  task automatic start();
    o_sda_low = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b0;
    #QTR;
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    #QTR o_scl = 1'b1;
    #QTR r = i_sda;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
endmodule

// *** bench/tcsp_top_monitor.sv ***
// Purpose: Port checker for the serial configuration block
// Assumes: Link far slower than i_clk
// Notes:   Filter times outlast any run; only guarded here
`timescale 1ns/1ps
module tcsp_mon
(
  // Clock, reset, link
  input wire logic                i_clk,
  input wire logic                i_rstn,
  input wire logic                i_scl,
  input wire logic                i_sda,
  input wire logic                o_sda,
  input wire logic                o_sda_oe,
  // Supervisor side
  input wire logic [3:0]          i_overcurrent,
  input wire logic [3:0]          i_power_good_output,
  input wire logic                i_powerup_done,
  input wire logic                i_powerdown,
  input wire logic                o_overcurrent_alarm_n,
  input wire logic                o_reset_n,
  input wire tcsp_pkg::tcsp_cfg_t o_cfg
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [3:0]  oc_en;
  logic [3:0]  sel;
  logic        all_good;
  int unsigned tmo;
  int unsigned good_q;
  assign oc_en = {o_cfg.oc_ctrl[2], o_cfg.oc_ctrl[3], o_cfg.oc_ctrl[4], o_cfg.oc_ctrl[5]};
  assign sel = {o_cfg.rst_ctrl[4], o_cfg.rst_ctrl[5], o_cfg.rst_ctrl[6], o_cfg.rst_ctrl[7]};
  assign all_good = &(i_power_good_output | ~sel);
  assign tmo = tcsp_pkg::RST_TMO_US[o_cfg.rst_ctrl[3:1]] * tcsp_pkg::CYC_PER_US;
  // Raw inputs lead the design's synced copy, so this count is an upper bound
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      good_q <= 0;
    else if (!all_good)
      good_q <= 0;
    else if (good_q != 32'hFFFFFFFF)
      good_q <= good_q + 1;
  a_sda_only_low: assert property (o_sda == 1'b0) else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda moved");
  a_reset_quiet: assert property ($rose(i_rstn) |-> o_cfg == 24'h000000 && !o_sda_oe
    && o_overcurrent_alarm_n && !o_reset_n) else $error("bad reset state");
  a_alarm_cause: assert property ($fell(o_overcurrent_alarm_n) |-> $past(i_powerup_done, 4)
    && |($past(i_overcurrent, 4) & oc_en)) else $error("alarm without cause");
  a_alarm_pdown: assert property (i_powerdown [*5] |-> o_overcurrent_alarm_n)
    else $error("alarm in power-down");
  a_rst_timeout: assert property ($rose(o_reset_n) |-> good_q >= tmo)
    else $error("reset released early");
  a_rst_hold: assert property (!all_good [*6] |-> !o_reset_n) else $error("reset not held");
  a_cfg_on_rise: assert property ($changed(o_cfg) |-> $past(i_scl, 3) || $past(i_scl, 4))
    else $error("config moved off a clock pulse");
  c_start: cover property (i_scl && $fell(i_sda));
  c_ack: cover property ($rose(o_sda_oe));
  c_rst_rel: cover property ($rose(o_reset_n));
endmodule
bind tcsp_top tcsp_mon u_mon
(
  .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .i_overcurrent(i_overcurrent),
  .i_power_good_output(i_power_good_output), .i_powerup_done(i_powerup_done),
  .i_powerdown(i_powerdown), .o_overcurrent_alarm_n(o_overcurrent_alarm_n),
  .o_reset_n(o_reset_n), .o_cfg(o_cfg)
);

// *** bench/tb_tracker_config_serial_port.sv ***
// Purpose: Self-checking bench for the serial configuration block
// Assumes: Only timeout code 000 is short enough to reach
// Notes:   Model is an int array of register contents
`timescale 1ns/1ps
module tb_tracker_config_serial_port;
  logic                i_clk, i_rstn, sda_low, scl, oe, ack, pd, pud, alarm_n, rst_n;
  logic [3:0]          oc, pg;
  logic [7:0]          q0, q1;
  logic [31:0]         seed = 32'h0000BEAB;
  int                  bad_count, num_checks, cyc, mdl [256];
  tcsp_pkg::tcsp_cfg_t cfg;
  wire                 sda = !(sda_low || oe);
  tcsp_master u_mst (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  tcsp_top DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda(),
    .o_sda_oe(oe), .i_overcurrent(oc), .i_power_good_output(pg), .i_powerup_done(pud),
    .i_powerdown(pd), .o_overcurrent_alarm_n(alarm_n), .o_reset_n(rst_n), .o_cfg(cfg));
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = !i_clk;
  end
  always @(posedge i_clk)
    if (++cyc == 30000)
    begin
      bad_count++;
      test_done();
    end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic head(input logic [7:0] ab, input logic ek, input logic [7:0] c);
    @(posedge i_clk);
    #7 u_mst.start();
    u_mst.xfer(ab, 1'b1, q0, ack);
    chk("ack", {7'h00, ek}, {7'h00, ack});
    u_mst.xfer(c, 1'b1, q0, ack);
  endtask
  // Unmapped places ignore writes and read as zero
  task automatic wr(input logic [7:0] a, d0, d1, input int n);
    head({tcsp_pkg::DEV_ADDR, 1'b0}, 1'b0, a);
    for (int i = 0; i < n; i++)
    begin
      u_mst.xfer(i ? d1 : d0, 1'b1, q0, ack);
      chk("wack", 8'h00, {7'h00, ack});
      if (8'(a + i) inside {8'h0D, 8'h0E, 8'h11, 8'h2D, 8'h2E, 8'h31})
        mdl[a + i] = i ? d1 : d0;
    end
    u_mst.stop();
  endtask
  task automatic rd2(input logic [7:0] a);
    head({tcsp_pkg::DEV_ADDR, 1'b0}, 1'b0, a);
    u_mst.start();
    u_mst.xfer({tcsp_pkg::DEV_ADDR, 1'b1}, 1'b1, q0, ack);
    u_mst.xfer(8'hFF, 1'b0, q0, ack);
    u_mst.xfer(8'hFF, 1'b1, q1, ack);
    u_mst.stop();
    chk("read0", 8'(mdl[a]), q0);
    chk("read1", 8'(mdl[a + 1]), q1);
  endtask
  task automatic cfg_chk();
    repeat (8) @(posedge i_clk);
    chk("thresh", 8'(mdl[8'h0D]), cfg.oc_thresh);
    chk("occtl", 8'(mdl[8'h0E]), cfg.oc_ctrl);
    chk("rstctl", 8'(mdl[8'h11]), cfg.rst_ctrl);
  endtask
  initial
  begin
    {i_rstn, oc, pg, pd, pud} = {1'b0, 4'h0, 4'hF, 1'b0, 1'b1};
    repeat (3) @(posedge i_clk);
    #7 i_rstn = 1'b1;
    cfg_chk();
    repeat (4)
    begin
      wr(8'h0D, rnd(), rnd(), 2);
      wr(8'h10, rnd(), rnd(), 2);
      cfg_chk();
      rd2(8'h0D);
      rd2(8'h10);
    end
    wr(8'h2D, 8'(mdl[8'h0D]), 8'(mdl[8'h0E]), 2);
    wr(8'h31, 8'(mdl[8'h11]), 8'h00, 1);
    rd2(8'h2D);
    wr(8'h0D, rnd(), rnd(), 2);
    wr(8'h11, rnd(), 8'h00, 1);
    wr(tcsp_pkg::CMD_REBOOT, 8'h00, 8'h00, 0);
    mdl[8'h0D] = mdl[8'h2D];
    mdl[8'h0E] = mdl[8'h2E];
    mdl[8'h11] = mdl[8'h31];
    cfg_chk();
    head({tcsp_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, 8'h0D);
    u_mst.stop();
    head({tcsp_pkg::DEV_ADDR, 1'b0}, 1'b0, 8'h0D);
    repeat (3) u_mst.bit_io(1'b0, ack);
    u_mst.stop();
    cfg_chk();
    wr(8'h0E, 8'h3C, 8'h00, 1);
    wr(8'h11, 8'h80, 8'h00, 1);
    pg = 4'hE;
    repeat (8) @(posedge i_clk);
    #7 chk("rst low", 8'h00, {7'h00, rst_n});
    pg = 4'h1;
    repeat (tcsp_pkg::RST_TMO_US[0] * tcsp_pkg::CYC_PER_US - 1) @(posedge i_clk);
    #7 chk("rst early", 8'h00, {7'h00, rst_n});
    oc = 4'(rnd()) | 4'h1;
    repeat (12) @(posedge i_clk);
    #7 chk("rst late", 8'h01, {7'h00, rst_n});
    repeat (300) @(posedge i_clk);
    #7 chk("alarm", 8'h01, {7'h00, alarm_n});
    pd = 1'b1;
    repeat (10) @(posedge i_clk);
    #7 chk("alarm pd", 8'h01, {7'h00, alarm_n});
    test_done();
  end
endmodule
